//--- logic/amci_mem_ctrl_irq.sv
// slot memory control, result flags and interrupt vector with avalon slave
//
// Notes on behaviour
// - slot entries frozen while conversion is enabled
// - bit 7 marks the last slot
// - bits 6-4 pick the reference pair
// - bits 3-0 pick the input channel
// - enable bit n gates flag n
// - result load into slot n sets flag n
// - slot access clears flag; software may write flags
// - vector reads zero when nothing pending
// - slot overflow 02h first, time overflow 04h next
// - flag n gives 06h plus 2n, low first
// - first slot address starts every sequence
// - mode field picks single, sequence, repeats
//
// Register access over Avalon-MM and the placing of the registers were decided locally.
`timescale 1ns/1ns
module amci_mem_ctrl_irq #(
  parameter int NUM_SLOTS = 16
) (
  input  wire logic                       ref_clk_i,
  input  wire logic                       reset_i,
  input  wire logic [7:0]                 avs_address_i,
  input  wire logic                       avs_read_i,
  input  wire logic                       avs_write_i,
  input  wire logic [31:0]                avs_writedata_i,
  input  wire logic [3:0]                 avs_byteenable_i,
  output logic      [31:0]                avs_readdata_o,
  output logic                            avs_waitrequest_o,
  input  wire amci_pkg::amci_core_rsp_t   core_rsp_i,
  input  wire logic                       conv_start_i,
  output logic                            conv_enable_o,
  output amci_pkg::amci_seq_mode_t        seq_mode_o,
  output logic      [3:0]                 cur_slot_o,
  output amci_pkg::amci_slot_ctrl_t       cur_ctrl_o,
  output logic                            busy_o,
  output logic                            irq_o
);

  // ==========================================================================
  // parameter check
  if (NUM_SLOTS < 2 || NUM_SLOTS > 16) begin : g_bad_slots
    $error("amci_mem_ctrl_irq: NUM_SLOTS must lie in 2..16");
  end

  localparam logic [3:0] LAST_SLOT = 4'(NUM_SLOTS - 1);

  // ==========================================================================
  // decode helpers
  function automatic logic region_hit(input logic [7:0] addr,
                                      input logic [7:0] base);
    return (addr[7:6] == base[7:6]) && (addr[1:0] == 2'h0) &&
           (addr[5:2] <= LAST_SLOT);
  endfunction : region_hit

  function automatic logic [3:0] slot_of(input logic [7:0] addr);
    return addr[5:2];
  endfunction : slot_of

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [15:0] wd,
                                          input logic [1:0]  be);
    return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction : merge16

  function automatic logic [3:0] next_slot(input logic [3:0] s);
    return (s == LAST_SLOT) ? 4'h0 : s + 4'h1;
  endfunction : next_slot

  // ==========================================================================
  // state
  amci_pkg::amci_slot_ctrl_t ctrl_q [NUM_SLOTS];
  logic [15:0]               result_q [NUM_SLOTS];
  logic [NUM_SLOTS-1:0]      ie_q;
  logic [NUM_SLOTS-1:0]      ifg_q;
  logic [NUM_SLOTS-1:0]      ifg_d;
  logic [2:0]                evt_q;
  logic [2:0]                evt_en_q;
  logic [2:0]                evt_set;
  logic [2:0]                evt_clr;
  logic                      en_q;
  amci_pkg::amci_seq_mode_t  mode_q;
  logic [3:0]                first_q;
  amci_pkg::amci_state_t     state_q;
  amci_pkg::amci_state_t     state_d;
  logic [3:0]                cur_slot_q;
  logic [3:0]                slot_d;
  amci_pkg::amci_slot_ctrl_t cur_ctrl_q;
  logic                      busy_q;
  logic [15:0]               iv_q;
  logic [15:0]               vec_now;
  logic                      irq_q;
  logic                      wait_q;
  logic [31:0]               rdata_q;
  logic [31:0]               rd_mux;
  logic                      req;
  logic                      acc;
  logic                      acc_wr;
  logic                      acc_rd;
  logic                      res_hit;
  logic                      ctl_hit;
  logic                      load;
  logic                      seq_end;

  // ==========================================================================
  // avalon slave: one wait cycle per request, then a single acceptance edge
  assign req     = avs_read_i | avs_write_i;
  assign acc     = req & ~wait_q;
  assign acc_wr  = acc & avs_write_i;
  assign acc_rd  = acc & avs_read_i;
  assign res_hit = region_hit(avs_address_i, amci_pkg::AMCI_RESULT_BASE);
  assign ctl_hit = region_hit(avs_address_i, amci_pkg::AMCI_SLOT_CTRL_BASE);

  // waitrequest idles high so a request is never taken before data is ready
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      wait_q <= 1'b1;
    end else if (acc) begin
      wait_q <= 1'b1;
    end else if (req) begin
      wait_q <= 1'b0;
    end
  end

  // read mux; unmapped and write-only addresses read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (avs_address_i)
      amci_pkg::AMCI_CTRL_OFF: begin
        rd_mux[amci_pkg::AMCI_CTRL_EN_BIT]         = en_q;
        rd_mux[amci_pkg::AMCI_CTRL_MODE_LSB +: 2]  = mode_q;
        rd_mux[amci_pkg::AMCI_CTRL_FIRST_LSB +: 4] = first_q;
      end
      amci_pkg::AMCI_STAT_OFF: begin
        rd_mux[amci_pkg::AMCI_STAT_BUSY_BIT]      = busy_q;
        rd_mux[amci_pkg::AMCI_STAT_SLOT_LSB +: 4] = cur_slot_q;
      end
      amci_pkg::AMCI_IE_OFF:       rd_mux[NUM_SLOTS-1:0] = ie_q;
      amci_pkg::AMCI_IFG_OFF:      rd_mux[NUM_SLOTS-1:0] = ifg_q;
      amci_pkg::AMCI_IV_OFF:       rd_mux[15:0] = iv_q;
      amci_pkg::AMCI_EVT_STAT_OFF: rd_mux[2:0] = evt_q;
      amci_pkg::AMCI_EVT_EN_OFF:   rd_mux[2:0] = evt_en_q;
      default: begin
        if (ctl_hit) begin
          rd_mux[7:0] = ctrl_q[slot_of(avs_address_i)];
        end else if (res_hit) begin
          rd_mux[15:0] = result_q[slot_of(avs_address_i)];
        end
      end
    endcase
  end

  // read data is caught in the wait cycle and stands at the accept edge
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_read_i && wait_q) begin
      rdata_q <= rd_mux;
    end
  end

  // ==========================================================================
  // main control word; mode and start slot locked while enabled
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      en_q    <= 1'b0;
      mode_q  <= amci_pkg::AMCI_SINGLE;
      first_q <= amci_pkg::AMCI_FIRST_RST;
    end else if (acc_wr && avs_address_i == amci_pkg::AMCI_CTRL_OFF &&
                 avs_byteenable_i[0]) begin
      en_q <= avs_writedata_i[amci_pkg::AMCI_CTRL_EN_BIT];
      if (!en_q) begin
        mode_q <= amci_pkg::amci_seq_mode_t'(
                    avs_writedata_i[amci_pkg::AMCI_CTRL_MODE_LSB +: 2]);
        // a start slot beyond the last one would never be reached
        if (avs_writedata_i[amci_pkg::AMCI_CTRL_FIRST_LSB +: 4] <= LAST_SLOT)
        begin
          first_q <= avs_writedata_i[amci_pkg::AMCI_CTRL_FIRST_LSB +: 4];
        end
      end
    end
  end

  // slot control entries, writes dropped while enabled
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        ctrl_q[i] <= amci_pkg::AMCI_SLOT_CTRL_RST;
      end
    end else if (acc_wr && ctl_hit && avs_byteenable_i[0] && !en_q) begin
      ctrl_q[slot_of(avs_address_i)] <=
        amci_pkg::amci_slot_ctrl_t'(avs_writedata_i[7:0]);
    end
  end

  // interrupt enables and event enables
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      ie_q     <= amci_pkg::AMCI_IE_RST[NUM_SLOTS-1:0];
      evt_en_q <= amci_pkg::AMCI_EVT_RST;
    end else if (acc_wr) begin
      if (avs_address_i == amci_pkg::AMCI_IE_OFF) begin
        ie_q <= NUM_SLOTS'(merge16(16'(ie_q), avs_writedata_i[15:0],
                                   avs_byteenable_i[1:0]));
      end
      if (avs_address_i == amci_pkg::AMCI_EVT_EN_OFF && avs_byteenable_i[0])
      begin
        evt_en_q <= avs_writedata_i[2:0];
      end
    end
  end

  // ==========================================================================
  // conversion sequencing
  assign load = core_rsp_i.result_valid && (state_q == amci_pkg::AMCI_RUN);

  always_comb begin
    state_d = state_q;
    slot_d  = cur_slot_q;
    seq_end = 1'b0;
    case (state_q)
      amci_pkg::AMCI_IDLE: begin
        if (en_q && conv_start_i) begin
          state_d = amci_pkg::AMCI_RUN;
          slot_d  = first_q;
        end
      end
      amci_pkg::AMCI_RUN: begin
        if (!en_q) begin
          state_d = amci_pkg::AMCI_IDLE;
        end else if (load) begin
          case (mode_q)
            amci_pkg::AMCI_SINGLE: begin
              state_d = amci_pkg::AMCI_IDLE;
              seq_end = 1'b1;
            end
            amci_pkg::AMCI_REP_SINGLE: begin
              slot_d = cur_slot_q;
            end
            amci_pkg::AMCI_SEQ: begin
              if (ctrl_q[cur_slot_q].eos) begin
                state_d = amci_pkg::AMCI_IDLE;
                seq_end = 1'b1;
              end else begin
                slot_d = next_slot(cur_slot_q);
              end
            end
            default: begin
              slot_d = ctrl_q[cur_slot_q].eos ? first_q
                                              : next_slot(cur_slot_q);
            end
          endcase
        end
      end
      default: state_d = amci_pkg::AMCI_IDLE;
    endcase
  end

  // sequencer registers; control entry lags the slot pointer by one cycle
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state_q    <= amci_pkg::AMCI_IDLE;
      cur_slot_q <= amci_pkg::AMCI_FIRST_RST;
      busy_q     <= 1'b0;
      cur_ctrl_q <= amci_pkg::AMCI_SLOT_CTRL_RST;
    end else begin
      state_q    <= state_d;
      cur_slot_q <= slot_d;
      busy_q     <= (state_d == amci_pkg::AMCI_RUN);
      cur_ctrl_q <= ctrl_q[cur_slot_q];
    end
  end

  // result memory holds data only, so it carries no reset
  always_ff @(posedge ref_clk_i) begin
    if (load) begin
      result_q[cur_slot_q] <= core_rsp_i.data;
    end else if (acc_wr && res_hit) begin
      result_q[slot_of(avs_address_i)] <= merge16(
        result_q[slot_of(avs_address_i)], avs_writedata_i[15:0],
        avs_byteenable_i[1:0]);
    end
  end

  // ==========================================================================
  // slot flags: software write, then access clear, then load set wins
  always_comb begin
    ifg_d = ifg_q;
    if (acc_wr && avs_address_i == amci_pkg::AMCI_IFG_OFF) begin
      ifg_d = NUM_SLOTS'(merge16(16'(ifg_q), avs_writedata_i[15:0],
                                 avs_byteenable_i[1:0]));
    end
    if (acc && res_hit) begin
      ifg_d[slot_of(avs_address_i)] = 1'b0;
    end
    if (load) begin
      ifg_d[cur_slot_q] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      ifg_q <= amci_pkg::AMCI_IFG_RST[NUM_SLOTS-1:0];
    end else begin
      ifg_q <= ifg_d;
    end
  end

  // sticky events; overwrite of an unread slot counts as overflow
  always_comb begin
    evt_set = 3'h0;
    evt_set[amci_pkg::AMCI_EVT_SLOT_OVF] = load & ifg_q[cur_slot_q];
    evt_set[amci_pkg::AMCI_EVT_TIME_OVF] = core_rsp_i.time_overflow;
    evt_set[amci_pkg::AMCI_EVT_SEQ_DONE] = seq_end;
    evt_clr = 3'h0;
    if (acc_wr && avs_address_i == amci_pkg::AMCI_EVT_CLR_OFF &&
        avs_byteenable_i[0]) begin
      evt_clr = avs_writedata_i[2:0];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      evt_q <= amci_pkg::AMCI_EVT_RST;
    end else begin
      evt_q <= (evt_q & ~evt_clr) | evt_set;
    end
  end

  // ==========================================================================
  // vector and request, registered one cycle after the sources
  amci_vec_enc #(
    .NUM_SLOTS (NUM_SLOTS)
  ) u_vec_enc (
    .slot_pend_i (ifg_q & ie_q),
    .slot_ovf_i  (evt_q[amci_pkg::AMCI_EVT_SLOT_OVF] &
                  evt_en_q[amci_pkg::AMCI_EVT_SLOT_OVF]),
    .time_ovf_i  (evt_q[amci_pkg::AMCI_EVT_TIME_OVF] &
                  evt_en_q[amci_pkg::AMCI_EVT_TIME_OVF]),
    .vector_o    (vec_now)
  );

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      iv_q  <= amci_pkg::AMCI_IV_RST;
      irq_q <= 1'b0;
    end else begin
      iv_q  <= vec_now;
      irq_q <= (|(ifg_q & ie_q)) | (|(evt_q & evt_en_q));
    end
  end

  // outputs, all straight from flops
  assign avs_readdata_o    = rdata_q;
  assign avs_waitrequest_o = wait_q;
  assign conv_enable_o     = en_q;
  assign seq_mode_o        = mode_q;
  assign cur_slot_o        = cur_slot_q;
  assign cur_ctrl_o        = cur_ctrl_q;
  assign busy_o            = busy_q;
  assign irq_o             = irq_q;

  // ==========================================================================
  // checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  logic                      lock_hit_q;
  logic [3:0]                lock_idx_q;
  amci_pkg::amci_slot_ctrl_t lock_val_q;

  always_ff @(posedge ref_clk_i) begin
    lock_hit_q <= acc_wr && ctl_hit && en_q;
    lock_idx_q <= slot_of(avs_address_i);
    lock_val_q <= ctrl_q[slot_of(avs_address_i)];
  end

  sequence s_start;
    (state_q == amci_pkg::AMCI_IDLE) && en_q && conv_start_i;
  endsequence
  sequence s_last_of_seq;
    load && en_q && (mode_q == amci_pkg::AMCI_SEQ) && ctrl_q[cur_slot_q].eos;
  endsequence
  sequence s_wrap;
    load && en_q && (mode_q == amci_pkg::AMCI_REP_SEQ) &&
    ctrl_q[cur_slot_q].eos;
  endsequence
  sequence s_bus_wait;
    req && wait_q;
  endsequence

  slot_lock_a: assert property (lock_hit_q |->
    ctrl_q[lock_idx_q] == lock_val_q) else $error("locked entry changed");
  flag_set_a: assert property (load |=> ifg_q[$past(cur_slot_q)])
    else $error("loaded slot flag not set");
  flag_clear_a: assert property ((acc && res_hit &&
    !(load && cur_slot_q == slot_of(avs_address_i)))
    |=> !ifg_q[$past(slot_of(avs_address_i))])
    else $error("accessed slot flag not cleared");
  irq_level_a: assert property ((|(ifg_q & ie_q)) |=> irq_o)
    else $error("enabled flag raised no request");
  irq_mask_a: assert property (((ifg_q & ie_q) == '0 &&
    (evt_q & evt_en_q) == 3'h0) |=> !irq_o)
    else $error("request without enabled source");
  vec_idle_a: assert property (((ifg_q & ie_q) == '0 &&
    (evt_q[1:0] & evt_en_q[1:0]) == 2'h0) |=> iv_q == 16'h0000)
    else $error("vector not zero when idle");
  vec_ovf_a: assert property ((evt_q[0] & evt_en_q[0])
    |=> iv_q == 16'h0002) else $error("slot overflow not first");
  vec_slot0_a: assert property ((ifg_q[0] & ie_q[0] &
    !(evt_q[0] & evt_en_q[0]) & !(evt_q[1] & evt_en_q[1]))
    |=> iv_q == 16'h0006) else $error("slot 0 vector wrong");
  seq_start_a: assert property (s_start |=>
    busy_o && cur_slot_q == $past(first_q)) else $error("bad first slot");
  eos_stop_a: assert property (s_last_of_seq |=> !busy_o ##1
    (!busy_o || $past(conv_start_i)))
    else $error("sequence ran past its marker");
  seq_wrap_a: assert property (s_wrap |=>
    busy_o && cur_slot_q == $past(first_q)) else $error("no wrap to first");
  bus_answer_a: assert property (s_bus_wait |=>
    !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("bus answer not one cycle");

endmodule : amci_mem_ctrl_irq

//--- logic/amci_pkg.sv
// package: register map, field layout and codes of the slot memory control
package amci_pkg;

  // ==========================================================================
  // register offsets, byte addresses on the 32-bit bus
  localparam logic [7:0] AMCI_CTRL_OFF       = 8'h00;
  localparam logic [7:0] AMCI_STAT_OFF       = 8'h04;
  localparam logic [7:0] AMCI_IE_OFF         = 8'h08;
  localparam logic [7:0] AMCI_IFG_OFF        = 8'h0C;
  localparam logic [7:0] AMCI_IV_OFF         = 8'h10;
  localparam logic [7:0] AMCI_EVT_STAT_OFF   = 8'h14;
  localparam logic [7:0] AMCI_EVT_CLR_OFF    = 8'h18;
  localparam logic [7:0] AMCI_EVT_EN_OFF     = 8'h1C;
  localparam logic [7:0] AMCI_SLOT_CTRL_BASE = 8'h40;
  localparam logic [7:0] AMCI_RESULT_BASE    = 8'h80;

  // ==========================================================================
  // field positions
  localparam int AMCI_CTRL_EN_BIT    = 0;
  localparam int AMCI_CTRL_MODE_LSB  = 1;
  localparam int AMCI_CTRL_FIRST_LSB = 4;
  localparam int AMCI_STAT_BUSY_BIT  = 0;
  localparam int AMCI_STAT_SLOT_LSB  = 4;
  localparam int AMCI_EVT_SLOT_OVF   = 0;
  localparam int AMCI_EVT_TIME_OVF   = 1;
  localparam int AMCI_EVT_SEQ_DONE   = 2;
  localparam int AMCI_EVT_W          = 3;

  // ==========================================================================
  // reset values
  localparam logic [7:0]  AMCI_SLOT_CTRL_RST = 8'h00;
  localparam logic [15:0] AMCI_IE_RST        = 16'h0000;
  localparam logic [15:0] AMCI_IFG_RST       = 16'h0000;
  localparam logic [15:0] AMCI_IV_RST        = 16'h0000;
  localparam logic [3:0]  AMCI_FIRST_RST     = 4'h0;
  localparam logic [2:0]  AMCI_EVT_RST       = 3'h0;

  // ==========================================================================
  // interrupt vector codes
  localparam logic [15:0] AMCI_VEC_NONE      = 16'h0000;
  localparam logic [15:0] AMCI_VEC_SLOT_OVF  = 16'h0002;
  localparam logic [15:0] AMCI_VEC_TIME_OVF  = 16'h0004;
  localparam logic [15:0] AMCI_VEC_SLOT_BASE = 16'h0006;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {
    AMCI_SINGLE     = 2'h0,
    AMCI_SEQ        = 2'h1,
    AMCI_REP_SINGLE = 2'h2,
    AMCI_REP_SEQ    = 2'h3
  } amci_seq_mode_t;

  typedef enum logic [1:0] {
    AMCI_IDLE = 2'h1,
    AMCI_RUN  = 2'h2
  } amci_state_t;

  // one slot control entry: marker, reference pair, input channel
  typedef struct packed {
    logic       eos;
    logic [2:0] ref_sel;
    logic [3:0] chan;
  } amci_slot_ctrl_t;

  // answer of the conversion core
  typedef struct packed {
    logic        result_valid;
    logic        time_overflow;
    logic [15:0] data;
  } amci_core_rsp_t;

endpackage : amci_pkg

//--- logic/amci_vec_enc.sv
// prioritised interrupt vector encoder of the slot memory control
`timescale 1ns/1ns
module amci_vec_enc #(
  parameter int NUM_SLOTS = 16
) (
  input  wire logic [NUM_SLOTS-1:0] slot_pend_i,
  input  wire logic                 slot_ovf_i,
  input  wire logic                 time_ovf_i,
  output logic      [15:0]          vector_o
);

  // ==========================================================================
  // parameter check
  if (NUM_SLOTS < 2 || NUM_SLOTS > 16) begin : g_bad_slots
    $error("amci_vec_enc: NUM_SLOTS must lie in 2..16");
  end

  // ==========================================================================
  // lowest pending slot wins, so scan downward and let the last hit stand
  function automatic logic [15:0] slot_code(
    input logic [NUM_SLOTS-1:0] pend
  );
    logic [15:0] code;
    code = amci_pkg::AMCI_VEC_NONE;
    for (int i = NUM_SLOTS - 1; i >= 0; i--) begin
      if (pend[i]) begin
        code = amci_pkg::AMCI_VEC_SLOT_BASE + 16'(2 * i);
      end
    end
    return code;
  endfunction : slot_code

  // overflow sources sit above every slot flag
  always_comb begin
    if (slot_ovf_i) begin
      vector_o = amci_pkg::AMCI_VEC_SLOT_OVF;
    end else if (time_ovf_i) begin
      vector_o = amci_pkg::AMCI_VEC_TIME_OVF;
    end else begin
      vector_o = slot_code(slot_pend_i);
    end
  end

endmodule : amci_vec_enc

//--- tb/amci_core_model.sv
// conversion core model: results and overflow pulses on command
`timescale 1ns/1ns
module amci_core_model (
  input  wire logic                 ref_clk_i,
  input  wire logic                 reset_i,
  input  wire logic                 busy_i,
  input  wire logic                 fire_i,
  input  wire logic                 tovf_i,
  output amci_pkg::amci_core_rsp_t  rsp_o
);
  logic [7:0] cnt_q;
  // ==========================================================================
  // core answer
  // a real core only converts inside a run, so pulses are gated by busy
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      rsp_o <= '0;
      cnt_q <= 8'h00;
    end else begin
      rsp_o.result_valid  <= fire_i & busy_i;
      rsp_o.time_overflow <= tovf_i & busy_i;
      rsp_o.data          <= {8'hA5, cnt_q};
      if (fire_i & busy_i) cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule : amci_core_model

//--- tb/adc_mem_ctrl_irq_logic_test.sv
// bench for slot memory control, flags and vector
`timescale 1ns/1ns
module adc_mem_ctrl_irq_logic_test;
  logic                      clk, rst, rd, wr, wreq, start, fire, tovf;
  logic                      conv_en, busy, irq;
  logic [7:0]                addr;
  logic [31:0]               wdata, rdata, q;
  logic [3:0]                cur_slot;
  amci_pkg::amci_core_rsp_t  rsp;
  amci_pkg::amci_seq_mode_t  mode;
  amci_pkg::amci_slot_ctrl_t cur_ctrl;
  int                        err_total, n_tests, n;

  // ==========================================================================
  // clock, design and core model
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  amci_mem_ctrl_irq dut (.ref_clk_i(clk), .reset_i(rst),
    .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdata), .avs_byteenable_i(4'hF),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
    .core_rsp_i(rsp), .conv_start_i(start), .conv_enable_o(conv_en),
    .seq_mode_o(mode), .cur_slot_o(cur_slot), .cur_ctrl_o(cur_ctrl),
    .busy_o(busy), .irq_o(irq));
  amci_core_model core (.ref_clk_i(clk), .reset_i(rst), .busy_i(busy),
    .fire_i(fire), .tovf_i(tovf), .rsp_o(rsp));

  // ==========================================================================
  // tasks
  task automatic complete_run();
    if (err_total == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  // request held until the edge that samples waitrequest low
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= ~w;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (wreq !== 1'b0 && i < 20);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    if (wreq !== 1'b0) begin
      err_total++;
      complete_run();
    end
  endtask : bus

  task automatic wrr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wrr

  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask : rdc

  // start pulse, then wait out the run under a bound
  task automatic run(input logic t, input int k);
    int i;
    @(posedge clk) start <= 1'b1;
    @(posedge clk) start <= 1'b0;
    fire <= 1'b1;
    tovf <= t;
    repeat (k) @(posedge clk);
    fire <= 1'b0;
    tovf <= 1'b0;
    for (i = 0; i < 20 && busy !== 1'b0; i++) @(posedge clk);
    if (busy !== 1'b0) begin
      err_total++;
      complete_run();
    end
  endtask : run

  // disable, set mode and first slot, start, then k cycles of results
  task automatic burst(input logic [31:0] cfg, input int k);
    wrr(8'h00, 32'h0);
    wrr(8'h00, cfg);
    @(posedge clk) start <= 1'b1;
    @(posedge clk) start <= 1'b0;
    fire <= 1'b1;
    repeat (k) @(posedge clk);
    fire <= 1'b0;
    #1 chk("rep busy", 1, busy);
  endtask : burst

  // ==========================================================================
  // main sequence
  initial begin
    {rst, rd, wr, start, fire, tovf} = 6'h20;
    {addr, wdata, err_total, n_tests} = '0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rdc("ie", 8'h08, 32'h0);
    rdc("ifg", 8'h0C, 32'h0);
    rdc("iv", 8'h10, 32'h0);
    rdc("slot5", 8'h54, 32'h0);
    rdc("unmapped", 8'hFC, 32'h0);
    wrr(8'h48, 32'h05);
    wrr(8'h4C, 32'hBA);
    rdc("slot3", 8'h4C, 32'hBA);
    wrr(8'h00, 32'h23);
    wrr(8'h48, 32'hFF);
    rdc("slot2 frozen", 8'h48, 32'h05);
    chk("conv en", 1, conv_en);
    chk("mode", 32'h1, mode);
    @(posedge clk) start <= 1'b1;
    @(posedge clk) start <= 1'b0;
    #1 chk("busy", 1, busy);
    chk("first slot", 2, cur_slot);
    @(posedge clk) fire <= 1'b1;
    #1 chk("cur ctrl", 32'h05, cur_ctrl);
    repeat (2) @(posedge clk);
    fire <= 1'b0;
    repeat (4) @(posedge clk) #1 chk("done", 0, busy);
    rdc("ifg seq", 8'h0C, 32'h000C);
    chk("irq masked", 0, irq);
    rdc("iv masked", 8'h10, 32'h0);
    wrr(8'h08, 32'h0008);
    rdc("iv slot3", 8'h10, 32'h000C);
    chk("irq on", 1, irq);
    wrr(8'h08, 32'h000C);
    rdc("iv slot2", 8'h10, 32'h000A);
    rdc("result2", 8'h88, 32'hA500);
    rdc("ifg cleared", 8'h0C, 32'h0008);
    wrr(8'h08, 32'hFFFF);
    for (n = 0; n < 16; n++) begin
      wrr(8'h0C, 32'h1 << n);
      rdc("iv n", 8'h10, 32'h6 + 2 * n);
    end
    wrr(8'h0C, 32'h8008);
    rdc("iv prio", 8'h10, 32'h000C);
    wrr(8'h1C, 32'h3);
    wrr(8'h00, 32'h00);
    wrr(8'h00, 32'h31);
    rdc("ctrl", 8'h00, 32'h31);
    run(1'b1, 1);
    rdc("stat", 8'h04, 32'h30);
    bus(1'b0, 8'h14, 32'h0);
    chk("events", 32'h7, q);
    rdc("iv slot ovf", 8'h10, 32'h0002);
    wrr(8'h18, 32'h1);
    rdc("iv time ovf", 8'h10, 32'h0004);
    wrr(8'h18, 32'h3);
    wrr(8'h0C, 32'h0);
    rdc("iv idle", 8'h10, 32'h0);
    chk("irq idle", 0, irq);
    // repeat sequence wraps to the first slot, repeat single stays
    burst(32'h27, 3);
    chk("rep seq wrap", 2, cur_slot);
    wrr(8'h00, 32'h0);
    @(posedge clk) #1 chk("rep seq stop", 3, cur_slot);
    chk("stopped", 0, busy);
    burst(32'h25, 3);
    chk("rep single", 2, cur_slot);
    wrr(8'h00, 32'h0);
    @(posedge clk) #1 chk("rep single stop", 2, cur_slot);
    chk("stopped", 0, busy);
    // second reset, with the sequencer already stopped, returns every output to idle
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk) #1 chk("rst busy", 0, busy);
    chk("rst irq", 0, irq);
    chk("rst slot", 0, cur_slot);
    chk("rst en", 0, conv_en);
    chk("rst wait", 1, wreq);
    rdc("rst ie", 8'h08, 32'h0);
    rdc("rst ifg", 8'h0C, 32'h0);
    complete_run();
  end
endmodule : adc_mem_ctrl_irq_logic_test
